// File: hw/ifr_map.vh
/*
  Register offsets, field positions, reset values, terminal function codes
  and timing counts for the input-terminal frequency reference block.
  Assumes a 32-bit APB bus with byte addresses and 0.1 % frequency units.
*/
`ifndef IFR_MAP_VH
`define IFR_MAP_VH

// register byte offsets
`define IFR_OFF_CTRL 8'h00
`define IFR_OFF_TFS0 8'h04
`define IFR_OFF_TFS1 8'h08
`define IFR_OFF_TFS2 8'h0c
`define IFR_OFF_UPPER 8'h10
`define IFR_OFF_LOWER 8'h14
`define IFR_OFF_MLOWER 8'h18
`define IFR_OFF_ACCEL 8'h1c
`define IFR_OFF_DECEL 8'h20
`define IFR_OFF_HELD 8'h24
`define IFR_OFF_STATUS 8'h28
`define IFR_OFF_FREQ 8'h2c

// field positions
`define IFR_CTRL_HOLDMEM 0
`define IFR_ST_RUN 0
`define IFR_ST_BASEBLOCK 1
`define IFR_ST_HOLD_ON 2
`define IFR_ST_UPDN_MODE 3
`define IFR_ST_CFG_ERR 4
`define IFR_ST_ERR_SINGLE 5
`define IFR_ST_ERR_MIX 6

// reset values, frequencies in 0.1 % of maximum output frequency
`define IFR_HOLDMEM_RST 1'b0
`define IFR_UPPER_RST 11'h3e8
`define IFR_LOWER_RST 11'h000
`define IFR_MLOWER_RST 11'h000
`define IFR_LIMIT_MAX 11'h44c
`define IFR_STEP_RST 11'h001
`define IFR_HELD_RST 11'h000
`define IFR_FN_NONE 8'hff

// terminal function codes
`define IFR_FN_BB_NO 8'h08
`define IFR_FN_BB_NC 8'h09
`define IFR_FN_HOLD 8'h0a
`define IFR_FN_UP 8'h10
`define IFR_FN_DOWN 8'h11

// ramp tick timing
`define IFR_CLK_MHZ 100
`define IFR_TICK_US 1000
`define IFR_TICK_CYC (`IFR_TICK_US * `IFR_CLK_MHZ)

`endif

// File: hw/ifr_input_ctrl.v
/*
  Multi-function contact input interpreter: baseblock, ramp hold and UP/DOWN
  frequency reference control with limits, hold memory and configuration
  error detection, configured over APB.
  Assumes contact inputs and run come from pins (synchronised here) and the
  analog reference comes from logic on clk_i.
*/
// Functional notes
// - Code 8 baseblocks on closed contact, code 9 on open contact.
// - Baseblock active inhibits the power output stage.
// - Baseblock release resumes via speed search toward the pre-baseblock reference; after release the ramp here targets the current reference.
// - Ramp hold input on freezes output frequency, operation continues.
// - Ramp hold off lets the ramp resume toward the reference.
// - Hold memory 0 starts from zero, 1 from retained held frequency.
// - Hold memory acts only when ramp hold or UP/DOWN is assigned.
// - Hold memory off and run given during ramp hold sets frequency zero.
// - Code 10 selects UP, code 11 selects DOWN, used as a pair.
// - UP/DOWN changes follow acceleration and deceleration rates.
// - Upper limit 0.0 to 110.0 % of maximum, default 100.0 %.
// - Lower limit same range, default 0.0 %.
// - Master reference lower limit 0.0 to 110.0 %, default 0.0 %.
// - Only one of UP or DOWN assigned raises configuration error.
// - UP/DOWN together with ramp hold raises configuration error.
// - UP/DOWN reference clamped; lower bound is largest of analog and limits.
// - Run with UP/DOWN accelerates output to the effective lower limit.
// - UP/DOWN in use disables multi-step speed selection.
// - Hold memory on keeps UP/DOWN reference; run accelerates to it.
// - UP or DOWN asserted while running clears stored reference to zero.
// - Each of ten terminals has its own function selection.
`include "ifr_map.vh"
`default_nettype none

module ifr_input_ctrl #(
  parameter TICK_CYCLES = `IFR_TICK_CYC
) (
  // clock and reset
  input wire clk_i,
  input wire srst_i,
  // apb slave
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [7:0] paddr_i,
  input wire [31:0] pwdata_i,
  output reg [31:0] prdata_o,
  output reg pready_o,
  output reg pslverr_o,
  // contact and reference inputs
  input wire [9:0] multi_input_terminal_i,
  input wire run_i,
  input wire [10:0] analog_ref_input_i,
  // drive outputs
  output reg [10:0] out_freq_o,
  output reg power_enable_o,
  output reg speed_search_o,
  output reg multistep_en_o,
  output reg input_config_error_o,
  output reg [10:0] held_ref_o
);

  localparam integer TICK_LAST = TICK_CYCLES - 1;

  // pin synchronisers
  reg [9:0] term_s1_reg;
  reg [9:0] term_s2_reg;
  reg run_s1_reg;
  reg run_s2_reg;

  always @(posedge clk_i) begin
    if (srst_i) begin
      term_s1_reg <= 10'h000;
      term_s2_reg <= 10'h000;
      run_s1_reg <= 1'b0;
      run_s2_reg <= 1'b0;
    end else begin
      term_s1_reg <= multi_input_terminal_i;
      term_s2_reg <= term_s1_reg;
      run_s1_reg <= run_i;
      run_s2_reg <= run_s1_reg;
    end
  end

  // apb access: one wait state, effect at the edge where pready is high
  wire acc = psel_i & penable_i;
  wire wr_en = acc & pready_o & pwrite_i;

  // configuration registers
  wire [79:0] terminal_function_select_w;
  reg hold_memory_select_reg;
  reg [10:0] ref_upper_limit_reg;
  reg [10:0] ref_lower_limit_reg;
  reg [10:0] master_ref_lower_limit_reg;
  reg [10:0] accel_step_reg;
  reg [10:0] decel_step_reg;

  wire [9:0] is_bb_no;
  wire [9:0] is_bb_nc;
  wire [9:0] is_hold;
  wire [9:0] is_up;
  wire [9:0] is_down;

  genvar gi;
  generate
    for (gi = 0; gi < 10; gi = gi + 1) begin : g_term
      localparam [7:0] WADDR = (gi < 4) ? `IFR_OFF_TFS0 :
                               ((gi < 8) ? `IFR_OFF_TFS1 : `IFR_OFF_TFS2);
      localparam integer LANE = gi % 4;
      reg [7:0] code_reg;
      wire [7:0] code = code_reg;
      always @(posedge clk_i) begin
        if (srst_i) begin
          code_reg <= `IFR_FN_NONE;
        end else if (wr_en && paddr_i == WADDR) begin
          code_reg <= pwdata_i[8*LANE +: 8];
        end
      end
      assign terminal_function_select_w[8*gi +: 8] = code_reg;
      assign is_bb_no[gi] = (code == `IFR_FN_BB_NO);
      assign is_bb_nc[gi] = (code == `IFR_FN_BB_NC);
      assign is_hold[gi] = (code == `IFR_FN_HOLD);
      assign is_up[gi] = (code == `IFR_FN_UP);
      assign is_down[gi] = (code == `IFR_FN_DOWN);
    end
  endgenerate

  // limit writes saturate at 110.0 %
  function [10:0] sat_limit;
    input [31:0] v;
    begin
      if (v > {21'h000000, `IFR_LIMIT_MAX}) begin
        sat_limit = `IFR_LIMIT_MAX;
      end else begin
        sat_limit = v[10:0];
      end
    end
  endfunction

  function [10:0] clamp3;
    input [10:0] v;
    input [10:0] lo;
    input [10:0] hi;
    begin
      if (v > hi) begin
        clamp3 = hi;
      end else if (v < lo) begin
        clamp3 = lo;
      end else begin
        clamp3 = v;
      end
    end
  endfunction

  always @(posedge clk_i) begin
    if (srst_i) begin
      hold_memory_select_reg <= `IFR_HOLDMEM_RST;
      ref_upper_limit_reg <= `IFR_UPPER_RST;
      ref_lower_limit_reg <= `IFR_LOWER_RST;
      master_ref_lower_limit_reg <= `IFR_MLOWER_RST;
      accel_step_reg <= `IFR_STEP_RST;
      decel_step_reg <= `IFR_STEP_RST;
    end else if (wr_en) begin
      case (paddr_i)
        `IFR_OFF_CTRL: hold_memory_select_reg <= pwdata_i[`IFR_CTRL_HOLDMEM];
        `IFR_OFF_UPPER: ref_upper_limit_reg <= sat_limit(pwdata_i);
        `IFR_OFF_LOWER: ref_lower_limit_reg <= sat_limit(pwdata_i);
        `IFR_OFF_MLOWER: master_ref_lower_limit_reg <= sat_limit(pwdata_i);
        `IFR_OFF_ACCEL: accel_step_reg <= pwdata_i[10:0];
        `IFR_OFF_DECEL: decel_step_reg <= pwdata_i[10:0];
        default: begin
        end
      endcase
    end
  end

  // function decode
  wire up_asg = |is_up;
  wire down_asg = |is_down;
  wire hold_asg = |is_hold;
  wire err_single = up_asg ^ down_asg;
  wire err_mix = (up_asg | down_asg) & hold_asg;
  wire cfg_err = err_single | err_mix;
  wire updn_mode = up_asg & down_asg & ~cfg_err;
  wire hold_mode = hold_asg & ~cfg_err;
  wire mem_en = hold_memory_select_reg & (hold_mode | updn_mode);

  wire bb_act = |((is_bb_no & term_s2_reg) | (is_bb_nc & ~term_s2_reg));
  wire hold_on = hold_mode & |(is_hold & term_s2_reg);
  wire up_on = updn_mode & |(is_up & term_s2_reg);
  wire down_on = updn_mode & |(is_down & term_s2_reg);
  wire press = up_on | down_on;
  wire run = run_s2_reg;

  // limits
  wire [10:0] cfg_lower = (ref_lower_limit_reg > master_ref_lower_limit_reg) ?
                          ref_lower_limit_reg : master_ref_lower_limit_reg;
  wire [10:0] eff_lower = (analog_ref_input_i > cfg_lower) ?
                          analog_ref_input_i : cfg_lower;

  // ramp tick divider
  reg [16:0] tick_cnt_reg;
  reg tick_reg;

  always @(posedge clk_i) begin
    if (srst_i) begin
      tick_cnt_reg <= 17'h00000;
      tick_reg <= 1'b0;
    end else if ({15'h0000, tick_cnt_reg} == TICK_LAST) begin
      tick_cnt_reg <= 17'h00000;
      tick_reg <= 1'b1;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 17'h00001;
      tick_reg <= 1'b0;
    end
  end

  // edge history
  reg run_prev_reg;
  reg bb_prev_reg;
  reg hold_prev_reg;
  reg press_prev_reg;
  wire run_rise = run & ~run_prev_reg;
  wire hold_rise = hold_on & ~hold_prev_reg;
  wire press_rise = press & ~press_prev_reg;
  wire bb_rise = bb_act & ~bb_prev_reg;
  wire bb_fall = ~bb_act & bb_prev_reg;

  always @(posedge clk_i) begin
    if (srst_i) begin
      run_prev_reg <= 1'b0;
      bb_prev_reg <= 1'b0;
      hold_prev_reg <= 1'b0;
      press_prev_reg <= 1'b0;
    end else begin
      run_prev_reg <= run;
      bb_prev_reg <= bb_act;
      hold_prev_reg <= hold_on;
      press_prev_reg <= press;
    end
  end

  // references
  reg [10:0] updn_ref_reg;
  reg [10:0] held_reg;
  reg [10:0] bb_ref_reg;
  reg [10:0] freq_reg;
  wire [11:0] up_sum = {1'b0, updn_ref_reg} + {1'b0, accel_step_reg};
  wire [11:0] dn_diff = {1'b0, updn_ref_reg} - {1'b0, decel_step_reg};
  wire [10:0] held_clamped = clamp3(held_reg, eff_lower, ref_upper_limit_reg);

  always @(posedge clk_i) begin
    if (srst_i) begin
      updn_ref_reg <= 11'h000;
    end else if (updn_mode && run_rise) begin
      updn_ref_reg <= mem_en ? held_clamped : eff_lower;
    end else if (updn_mode && run && tick_reg) begin
      if (up_on && !down_on) begin
        if (up_sum > {1'b0, ref_upper_limit_reg}) begin
          updn_ref_reg <= ref_upper_limit_reg;
        end else begin
          updn_ref_reg <= up_sum[10:0];
        end
      end else if (down_on && !up_on) begin
        if (dn_diff[11] || dn_diff[10:0] < eff_lower) begin
          updn_ref_reg <= eff_lower;
        end else begin
          updn_ref_reg <= dn_diff[10:0];
        end
      end else begin
        updn_ref_reg <= clamp3(updn_ref_reg, eff_lower, ref_upper_limit_reg);
      end
    end
  end

  // held frequency: software restores it after power-up, reads it to save
  always @(posedge clk_i) begin
    if (srst_i) begin
      held_reg <= `IFR_HELD_RST;
    end else if (updn_mode && run && press_rise) begin
      held_reg <= 11'h000;
    end else if (hold_rise && run) begin
      held_reg <= freq_reg;
    end else if (updn_mode && run && !press && mem_en) begin
      held_reg <= updn_ref_reg;
    end else if (wr_en && paddr_i == `IFR_OFF_HELD) begin
      held_reg <= pwdata_i[10:0];
    end
  end

  // target without baseblock, then with it
  reg [10:0] tgt_free;
  always @* begin
    if (!run) begin
      tgt_free = 11'h000;
    end else if (updn_mode) begin
      tgt_free = updn_ref_reg;
    end else begin
      tgt_free = clamp3(analog_ref_input_i, cfg_lower, ref_upper_limit_reg);
    end
  end

  always @(posedge clk_i) begin
    if (srst_i) begin
      bb_ref_reg <= 11'h000;
    end else if (bb_rise) begin
      bb_ref_reg <= tgt_free;
    end
  end

  wire [10:0] target = (bb_act && run) ? bb_ref_reg : tgt_free;
  wire [11:0] f_up = {1'b0, freq_reg} + {1'b0, accel_step_reg};
  wire [11:0] f_dn = {1'b0, freq_reg} - {1'b0, decel_step_reg};

  // output frequency ramp
  always @(posedge clk_i) begin
    if (srst_i) begin
      freq_reg <= 11'h000;
    end else if (run_rise && hold_on) begin
      freq_reg <= mem_en ? held_reg : 11'h000;
    end else if (run && hold_on) begin
      freq_reg <= freq_reg;
    end else if (tick_reg && !bb_act) begin
      if (freq_reg < target) begin
        freq_reg <= (f_up > {1'b0, target}) ? target : f_up[10:0];
      end else if (freq_reg > target) begin
        freq_reg <= (f_dn[11] || f_dn[10:0] < target) ? target : f_dn[10:0];
      end
    end
  end

  // registered outputs
  always @(posedge clk_i) begin
    if (srst_i) begin
      out_freq_o <= 11'h000;
      power_enable_o <= 1'b0;
      speed_search_o <= 1'b0;
      multistep_en_o <= 1'b1;
      input_config_error_o <= 1'b0;
      held_ref_o <= `IFR_HELD_RST;
    end else begin
      out_freq_o <= freq_reg;
      power_enable_o <= run & ~bb_act;
      speed_search_o <= bb_fall & run;
      multistep_en_o <= ~updn_mode;
      input_config_error_o <= cfg_err;
      held_ref_o <= held_reg;
    end
  end

  // apb read and answer
  wire [31:0] status_w = {25'h0000000, err_mix, err_single, cfg_err, updn_mode,
                          hold_on, bb_act, run};
  reg [31:0] rdata;
  reg hit;
  always @* begin
    hit = 1'b1;
    rdata = 32'h00000000;
    case (paddr_i)
      `IFR_OFF_CTRL: rdata = {31'h00000000, hold_memory_select_reg};
      `IFR_OFF_TFS0: rdata = terminal_function_select_w[31:0];
      `IFR_OFF_TFS1: rdata = terminal_function_select_w[63:32];
      `IFR_OFF_TFS2: rdata = {16'h0000, terminal_function_select_w[79:64]};
      `IFR_OFF_UPPER: rdata = {21'h000000, ref_upper_limit_reg};
      `IFR_OFF_LOWER: rdata = {21'h000000, ref_lower_limit_reg};
      `IFR_OFF_MLOWER: rdata = {21'h000000, master_ref_lower_limit_reg};
      `IFR_OFF_ACCEL: rdata = {21'h000000, accel_step_reg};
      `IFR_OFF_DECEL: rdata = {21'h000000, decel_step_reg};
      `IFR_OFF_HELD: rdata = {21'h000000, held_reg};
      `IFR_OFF_STATUS: rdata = status_w;
      `IFR_OFF_FREQ: rdata = {10'h000, updn_ref_reg, freq_reg};
      default: hit = 1'b0;
    endcase
  end

  always @(posedge clk_i) begin
    if (srst_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h00000000;
    end else if (acc && !pready_o) begin
      pready_o <= 1'b1;
      pslverr_o <= ~hit;
      prdata_o <= pwrite_i ? 32'h00000000 : rdata;
    end else begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// File: verification/ifr_input_ctrl_checker.sv
/* checker for the input terminal reference block, bound to its ports.
   assumes an APB master with setup and access phases. */
`default_nettype none
module ifr_input_ctrl_checker #(
  parameter int TICK_CYCLES = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // apb
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // pins and drive
  input wire logic run_i,
  input wire logic [10:0] out_freq_o,
  input wire logic power_enable_o,
  input wire logic speed_search_o,
  input wire logic multistep_en_o,
  input wire logic input_config_error_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  sequence s_setup;
    psel_i && !penable_i;
  endsequence
  sequence s_answer;
    penable_i ##1 pready_o;
  endsequence
  a_apb_one_wait: assert property (s_setup |=> s_answer)
    else $error("ready not in second access cycle");
  a_ready_single: assert property (pready_o |=> !pready_o)
    else $error("ready longer than one cycle");
  a_err_unmapped: assert property (pready_o && paddr_i > 8'h2c |-> pslverr_o && prdata_o == 0)
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (pready_o && paddr_i <= 8'h2c && paddr_i[1:0] == 0 |-> !pslverr_o)
    else $error("mapped access refused");
  a_run_off_power: assert property (!run_i [*4] |-> !power_enable_o)
    else $error("output on without run");
  a_search_pulse: assert property (speed_search_o |=> !speed_search_o)
    else $error("search pulse too long");
  a_search_stopped: assert property (!run_i [*4] |-> !speed_search_o)
    else $error("search while stopped");
  a_cfg_multistep: assert property (input_config_error_o |-> multistep_en_o)
    else $error("multistep off under config error");
  a_freq_ceiling: assert property (out_freq_o <= 11'h44c)
    else $error("frequency above limit");
endmodule
bind ifr_input_ctrl ifr_input_ctrl_checker #(.TICK_CYCLES(TICK_CYCLES)) ifr_input_ctrl_checker_i (
  .clk_i(clk_i), .srst_i(srst_i), .psel_i(psel_i), .penable_i(penable_i), .paddr_i(paddr_i),
  .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .run_i(run_i),
  .out_freq_o(out_freq_o), .power_enable_o(power_enable_o), .speed_search_o(speed_search_o),
  .multistep_en_o(multistep_en_o), .input_config_error_o(input_config_error_o));
`default_nettype wire

// File: verification/ifr_contact_model.sv
/* contact and run pin model of the machine controller.
   assumes one bench process calls its tasks; open contact reads 0. */
`default_nettype none
module ifr_contact_model (
  // clock
  input wire logic clk_i,
  // pins
  output logic [9:0] contacts_o,
  output logic run_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    contacts_o = 10'h000;
    run_o = 1'b0;
  end
  task automatic set_contact(input int idx, input logic v);
    @(posedge clk_i);
    contacts_o[idx] <= v;
  endtask
  // run may be given while hold is on to reuse the retained frequency
  task automatic set_run(input logic v);
    @(posedge clk_i);
    run_o <= v;
  endtask
endmodule
`default_nettype wire

// File: verification/tb_ifr_input_ctrl.sv
/* self-checking bench for the input terminal reference block.
   assumes the design header is on the include path. */
`include "ifr_map.vh"
`default_nettype none
module tb_ifr_input_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i, srst_i, psel, penable, pwrite, err, seen, run;
  logic [7:0] paddr;
  logic [31:0] pwdata, rd, prdata_o;
  logic [10:0] analog, out_freq_o, held_ref_o, f;
  logic [9:0] contacts;
  logic pready_o, pslverr_o, power_enable_o, speed_search_o, multistep_en_o, input_config_error_o;
  logic [31:0] cfg [3] = '{32'hffffff10, 32'hff0a1110, 32'hffff1110};
  logic cfg_err [3] = '{1'b1, 1'b1, 1'b0};
  int miscompares = 0;
  int compares = 0;
  ifr_input_ctrl #(.TICK_CYCLES(8)) ifr_input_ctrl_i (
    .clk_i(clk_i), .srst_i(srst_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .multi_input_terminal_i(contacts), .run_i(run),
    .analog_ref_input_i(analog), .out_freq_o(out_freq_o), .power_enable_o(power_enable_o),
    .speed_search_o(speed_search_o), .multistep_en_o(multistep_en_o),
    .input_config_error_o(input_config_error_o), .held_ref_o(held_ref_o));
  ifr_contact_model ifr_contact_model_i (.clk_i(clk_i), .contacts_o(contacts), .run_o(run));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic report_and_stop();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    if (pready_o !== 1'b1) begin
      miscompares++;
      $display("mismatch at %0t: apb answer timeout", $time);
      report_and_stop();
    end else begin
      rd = prdata_o;
      err = pslverr_o;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string msg);
    apb(1'b0, a, 32'h0);
    chk(rd, exp, msg);
  endtask
  task automatic waitf(input logic [10:0] exp, input string msg);
    int n;
    n = 0;
    while (out_freq_o !== exp && n < 3000) begin
      @(posedge clk_i);
      n++;
    end
    chk({21'h0, out_freq_o}, {21'h0, exp}, msg);
    if (out_freq_o !== exp) report_and_stop();
  endtask
  initial begin
    srst_i = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    analog = 11'h000;
    cyc(20);
    srst_i <= 1'b0;
    rdchk(`IFR_OFF_CTRL, 32'h0, "ctrl");
    rdchk(`IFR_OFF_UPPER, 32'h3e8, "upper");
    rdchk(`IFR_OFF_LOWER, 32'h0, "lower");
    rdchk(`IFR_OFF_MLOWER, 32'h0, "mlower");
    rdchk(`IFR_OFF_TFS0, 32'hffffffff, "tfs0");
    rdchk(8'h30, 32'h0, "unmapped");
    chk({31'h0, err}, 32'h1, "slverr");
    apb(1'b1, `IFR_OFF_UPPER, 32'h500);
    rdchk(`IFR_OFF_UPPER, 32'h44c, "upper sat");
    $display("test registers done");
    apb(1'b1, `IFR_OFF_TFS0, 32'hffffff08);
    ifr_contact_model_i.set_run(1'b1);
    cyc(6);
    chk({31'h0, power_enable_o}, 32'h1, "run");
    ifr_contact_model_i.set_contact(0, 1'b1);
    cyc(6);
    chk({31'h0, power_enable_o}, 32'h0, "bb no");
    ifr_contact_model_i.set_contact(0, 1'b0);
    seen = 1'b0;
    repeat (8) begin
      @(posedge clk_i);
      if (speed_search_o === 1'b1) seen = 1'b1;
    end
    chk({31'h0, seen}, 32'h1, "search");
    apb(1'b1, `IFR_OFF_TFS0, 32'hffffff09);
    cyc(6);
    chk({31'h0, power_enable_o}, 32'h0, "bb nc");
    ifr_contact_model_i.set_run(1'b0);
    $display("test baseblock done");
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, `IFR_OFF_TFS0, cfg[i]);
      cyc(3);
      chk({31'h0, input_config_error_o}, {31'h0, cfg_err[i]}, "cfg");
    end
    chk({31'h0, multistep_en_o}, 32'h0, "multistep");
    $display("test config done");
    apb(1'b1, `IFR_OFF_UPPER, 32'h20);
    apb(1'b1, `IFR_OFF_CTRL, 32'h1);
    apb(1'b1, `IFR_OFF_HELD, 32'h18);
    analog <= 11'h010;
    ifr_contact_model_i.set_run(1'b1);
    waitf(11'h018, "stored ref");
    ifr_contact_model_i.set_contact(0, 1'b1);
    cyc(5);
    chk({21'h0, held_ref_o}, 32'h0, "held clear");
    chk({31'h0, out_freq_o < 11'h1a}, 32'h1, "ramped");
    waitf(11'h020, "up clamp");
    ifr_contact_model_i.set_contact(0, 1'b0);
    ifr_contact_model_i.set_contact(1, 1'b1);
    waitf(11'h010, "down clamp");
    ifr_contact_model_i.set_contact(1, 1'b0);
    ifr_contact_model_i.set_run(1'b0);
    waitf(11'h000, "stop");
    apb(1'b1, `IFR_OFF_HELD, 32'h1c);
    apb(1'b1, `IFR_OFF_CTRL, 32'h0);
    ifr_contact_model_i.set_run(1'b1);
    cyc(300);
    chk({21'h0, out_freq_o}, 32'h10, "lower start");
    ifr_contact_model_i.set_run(1'b0);
    waitf(11'h000, "stop");
    apb(1'b1, `IFR_OFF_CTRL, 32'h1);
    $display("test up down done");
    apb(1'b1, `IFR_OFF_TFS0, 32'hffffff0a);
    apb(1'b1, `IFR_OFF_UPPER, 32'h3e8);
    analog <= 11'h040;
    ifr_contact_model_i.set_run(1'b1);
    cyc(100);
    ifr_contact_model_i.set_contact(0, 1'b1);
    cyc(6);
    f = out_freq_o;
    cyc(80);
    chk({21'h0, out_freq_o}, {21'h0, f}, "frozen");
    ifr_contact_model_i.set_contact(0, 1'b0);
    waitf(11'h040, "resumed");
    ifr_contact_model_i.set_run(1'b0);
    waitf(11'h000, "stop");
    ifr_contact_model_i.set_contact(0, 1'b1);
    cyc(6);
    apb(1'b1, `IFR_OFF_HELD, 32'h30);
    ifr_contact_model_i.set_run(1'b1);
    cyc(8);
    chk({21'h0, out_freq_o}, 32'h30, "mem on");
    ifr_contact_model_i.set_run(1'b0);
    apb(1'b1, `IFR_OFF_CTRL, 32'h0);
    ifr_contact_model_i.set_run(1'b1);
    cyc(8);
    chk({21'h0, out_freq_o}, 32'h0, "mem off");
    $display("test ramp hold done");
    report_and_stop();
  end
endmodule
`default_nettype wire
